/* File: hw/wake_pin_detector.sv */
// wake pin detector: filtered wake events, flags, masks and mode wake requests
// What this block does
// - both pin edge directions count as wake
// - new level must persist 10 to 25 us
// - software enable switches pin wake capability
// - pin edges ignored while supply is off
// - pin level readable in normal, stop, flash
// - enabled edge wakes device from sleep
// - any edge in fail-safe requests restart
// - enabled edge in active modes sets flag, interrupt
// - rise and fall interrupts masked separately
// - pending flag at sleep entry wakes again
`timescale 1ns/1ps
`include "wake_pin_detector_regs.svh"
module wake_pin_detector #(
   parameter int FILTER_CYCLES = `WAKE_FILTER_CYCLES,
   parameter int CNT_W = 11
) (
   input wire logic clk,                 // 50 MHz
   input wire logic rst_b,               // async reset, active low
   input wire logic wake_input_pin,      // external wake pin
   input wire logic supply_ok,           // supply above off threshold
   input wire wake_pkg::mode_type mode,  // present device mode
   input wire logic [7:0] reg_addr,      // register byte address
   input wire logic [31:0] reg_wdata,    // register write data
   input wire logic reg_wr,              // write strobe
   input wire logic reg_rd,              // read strobe
   output logic [31:0] reg_rdata,        // read data, cycle after strobe
   output logic wake_from_sleep,         // request to leave sleep
   output logic restart_req,             // request fail-safe to restart
   output logic wake_irq                 // unmasked flag pending
);
   wake_filter_if fif();

   logic wake_input_enable_q;
   logic mask_a_q;
   logic mask_b_q;
   logic wake_edge_flag_a_q;
   logic wake_edge_flag_b_q;
   logic wake_from_sleep_q;
   logic restart_req_q;
   logic wake_irq_q;
   logic [31:0] reg_rdata_q;

   logic active;
   logic in_sleep;
   logic in_failsafe;
   logic any_edge;
   logic wr_ctrl;
   logic wr_stat;
   logic set_a;
   logic set_b;
   logic clr_a;
   logic clr_b;
   logic wake_level_status;
   logic [31:0] rd_word;

   // one offset decoder shared by the write side, the read side and every check except p_level_read
   function automatic logic hits(input logic [7:0] addr, input logic [7:0] offset);
      return addr == offset;
   endfunction

   if (FILTER_CYCLES < 2 || FILTER_CYCLES >= (1 << CNT_W)) begin : g_chk
      $error("filter length does not fit the counter");
   end

   wake_glitch_filter #(
      .FILTER_CYCLES(FILTER_CYCLES),
      .CNT_W(CNT_W)
   ) u_filter (
      .clk(clk),
      .rst_b(rst_b),
      .pin(wake_input_pin),
      .fi(fif.filt)
   );

   assign fif.run = supply_ok;

   always_comb begin
      active = (mode == wake_pkg::MODE_NORMAL) || (mode == wake_pkg::MODE_STOP) ||
               (mode == wake_pkg::MODE_FLASH);
      in_sleep = (mode == wake_pkg::MODE_SLEEP);
      in_failsafe = (mode == wake_pkg::MODE_FAILSAFE);
      any_edge = supply_ok && (fif.rise || fif.fall);
      wr_ctrl = reg_wr && hits(reg_addr, `WAKE_CTRL_OFFSET);
      wr_stat = reg_wr && hits(reg_addr, `WAKE_STAT_OFFSET);
      set_a = supply_ok && wake_input_enable_q && active && fif.rise;
      set_b = supply_ok && wake_input_enable_q && active && fif.fall;
      clr_a = wr_stat && reg_wdata[`WAKE_STAT_FLAG_A_BIT];
      clr_b = wr_stat && reg_wdata[`WAKE_STAT_FLAG_B_BIT];
      wake_level_status = active && fif.pin_now;
   end

   // control register
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         {mask_b_q, mask_a_q, wake_input_enable_q} <= `WAKE_CTRL_RESET;
      end else if (wr_ctrl) begin
         wake_input_enable_q <= reg_wdata[`WAKE_CTRL_EN_BIT];
         mask_a_q <= reg_wdata[`WAKE_CTRL_MASK_A_BIT];
         mask_b_q <= reg_wdata[`WAKE_CTRL_MASK_B_BIT];
      end
   end

   // direction flags, write one to clear; a new edge beats the clear
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wake_edge_flag_a_q <= 1'b0;
         wake_edge_flag_b_q <= 1'b0;
      end else begin
         wake_edge_flag_a_q <= set_a || (wake_edge_flag_a_q && !clr_a);
         wake_edge_flag_b_q <= set_b || (wake_edge_flag_b_q && !clr_b);
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wake_irq_q <= 1'b0;
      end else begin
         wake_irq_q <= (wake_edge_flag_a_q && !mask_a_q) ||
                       (wake_edge_flag_b_q && !mask_b_q);
      end
   end

   // sleep exit: enabled edge, or a flag left over from before sleep
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wake_from_sleep_q <= 1'b0;
      end else if (!supply_ok || !in_sleep) begin
         wake_from_sleep_q <= 1'b0;
      end else if ((wake_input_enable_q && any_edge) ||
                   wake_edge_flag_a_q || wake_edge_flag_b_q) begin
         wake_from_sleep_q <= 1'b1;
      end
   end

   // fail-safe exit ignores the enable
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         restart_req_q <= 1'b0;
      end else if (!supply_ok || !in_failsafe) begin
         restart_req_q <= 1'b0;
      end else if (any_edge) begin
         restart_req_q <= 1'b1;
      end
   end

   always_comb begin
      rd_word = 32'h0000_0000;
      if (hits(reg_addr, `WAKE_CTRL_OFFSET)) begin
         rd_word[`WAKE_CTRL_EN_BIT] = wake_input_enable_q;
         rd_word[`WAKE_CTRL_MASK_A_BIT] = mask_a_q;
         rd_word[`WAKE_CTRL_MASK_B_BIT] = mask_b_q;
      end else if (hits(reg_addr, `WAKE_STAT_OFFSET)) begin
         rd_word[`WAKE_STAT_LEVEL_BIT] = wake_level_status;
         rd_word[`WAKE_STAT_FLAG_A_BIT] = wake_edge_flag_a_q;
         rd_word[`WAKE_STAT_FLAG_B_BIT] = wake_edge_flag_b_q;
      end
   end

   // read data stand for one cycle only, zero otherwise
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata_q <= 32'h0000_0000;
      end else if (reg_rd) begin
         reg_rdata_q <= rd_word;
      end else begin
         reg_rdata_q <= 32'h0000_0000;
      end
   end

   assign reg_rdata = reg_rdata_q;
   assign wake_from_sleep = wake_from_sleep_q;
   assign restart_req = restart_req_q;
   assign wake_irq = wake_irq_q;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   property p_rise_flag;
      (set_a && !clr_a) |=> wake_edge_flag_a_q;
   endproperty
   a_rise_flag: assert property (p_rise_flag) else $error("rise flag not set");

   property p_set_wins;
      (set_a && clr_a) |=> wake_edge_flag_a_q;
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("clear beat a new edge");

   property p_fall_flag;
      (supply_ok && wake_input_enable_q && active && fif.fall) |=> wake_edge_flag_b_q;
   endproperty
   a_fall_flag: assert property (p_fall_flag) else $error("fall flag not set");

   property p_disabled_no_flag;
      (!wake_input_enable_q && !wake_edge_flag_a_q && !wake_edge_flag_b_q) |=>
         (!wake_edge_flag_a_q && !wake_edge_flag_b_q);
   endproperty
   a_disabled_no_flag: assert property (p_disabled_no_flag) else $error("flag while off");

   property p_irq_mask;
      (wake_edge_flag_a_q && mask_a_q && !wake_edge_flag_b_q) |=> !wake_irq_q;
   endproperty
   a_irq_mask: assert property (p_irq_mask) else $error("masked rise raised irq");

   property p_irq_unmask;
      (wake_edge_flag_b_q && !mask_b_q) |=> wake_irq_q;
   endproperty
   a_irq_unmask: assert property (p_irq_unmask) else $error("unmasked fall no irq");

   property p_sleep_wake;
      (in_sleep && supply_ok && wake_input_enable_q && fif.rise) |=> wake_from_sleep_q;
   endproperty
   a_sleep_wake: assert property (p_sleep_wake) else $error("no wake from sleep");

   sequence s_flag_pending;
      active && !reg_wr && (wake_edge_flag_a_q || wake_edge_flag_b_q);
   endsequence

   sequence s_enter_sleep;
      in_sleep && supply_ok;
   endsequence

   property p_pending_wake;
      s_flag_pending ##1 s_enter_sleep |=> wake_from_sleep_q;
   endproperty
   a_pending_wake: assert property (p_pending_wake) else $error("pending flag lost");

   property p_failsafe;
      (in_failsafe && any_edge) |=> restart_req_q;
   endproperty
   a_failsafe: assert property (p_failsafe) else $error("no restart request");

   property p_off_quiet;
      !supply_ok |=> (!wake_from_sleep_q && !restart_req_q);
   endproperty
   a_off_quiet: assert property (p_off_quiet) else $error("activity while off");

   property p_level_read;
      (reg_rd && reg_addr == `WAKE_STAT_OFFSET && active) |=>
         reg_rdata_q[`WAKE_STAT_LEVEL_BIT] == $past(fif.pin_now);
   endproperty
   a_level_read: assert property (p_level_read) else $error("level status wrong");

   property p_read_once;
      !reg_rd |=> reg_rdata_q == 32'h0000_0000;
   endproperty
   a_read_once: assert property (p_read_once) else $error("read data held too long");

   property p_fall_wins;
      (set_b && clr_b) |=> wake_edge_flag_b_q;
   endproperty
   a_fall_wins: assert property (p_fall_wins) else $error("clear beat a new fall");

   property p_irq_mask_b;
      (wake_edge_flag_b_q && mask_b_q && !wake_edge_flag_a_q) |=> !wake_irq_q;
   endproperty
   a_irq_mask_b: assert property (p_irq_mask_b) else $error("masked fall raised irq");

   property p_level_hidden;
      (reg_rd && hits(reg_addr, `WAKE_STAT_OFFSET) && !active) |=>
         !reg_rdata_q[`WAKE_STAT_LEVEL_BIT];
   endproperty
   a_level_hidden: assert property (p_level_hidden) else $error("level shown off mode");

   property p_restart_only;
      !in_failsafe |=> !restart_req_q;
   endproperty
   a_restart_only: assert property (p_restart_only) else $error("restart outside fail-safe");

   property p_wake_only;
      !in_sleep |=> !wake_from_sleep_q;
   endproperty
   a_wake_only: assert property (p_wake_only) else $error("wake request outside sleep");

   property p_no_flag_idle;
      (!active && !wake_edge_flag_a_q && !wake_edge_flag_b_q) |=>
         (!wake_edge_flag_a_q && !wake_edge_flag_b_q);
   endproperty
   a_no_flag_idle: assert property (p_no_flag_idle) else $error("flag set off mode");

   property p_ctrl_write;
      wr_ctrl |=> wake_input_enable_q == $past(reg_wdata[`WAKE_CTRL_EN_BIT]);
   endproperty
   a_ctrl_write: assert property (p_ctrl_write) else $error("enable not written");

   property p_ctrl_read;
      (reg_rd && hits(reg_addr, `WAKE_CTRL_OFFSET)) |=>
         reg_rdata_q[`WAKE_CTRL_EN_BIT] == $past(wake_input_enable_q);
   endproperty
   a_ctrl_read: assert property (p_ctrl_read) else $error("enable read wrong");

   sequence s_restart_raised;
      in_failsafe && supply_ok && restart_req_q;
   endsequence

   property p_restart_holds;
      s_restart_raised |=> restart_req_q;
   endproperty
   a_restart_holds: assert property (p_restart_holds) else $error("restart dropped");

   sequence s_wake_raised;
      in_sleep && supply_ok && wake_from_sleep_q;
   endsequence

   property p_wake_holds;
      s_wake_raised |=> wake_from_sleep_q;
   endproperty
   a_wake_holds: assert property (p_wake_holds) else $error("sleep wake dropped");

   property p_irq_quiet;
      (!wake_edge_flag_a_q && !wake_edge_flag_b_q) |=> !wake_irq_q;
   endproperty
   a_irq_quiet: assert property (p_irq_quiet) else $error("irq without flag");
endmodule

/* File: hw/wake_pin_detector_regs.svh */
// register offsets, field positions, reset values and timing counts of the wake detector
`ifndef WAKE_PIN_DETECTOR_REGS_SVH
`define WAKE_PIN_DETECTOR_REGS_SVH

`define WAKE_CTRL_OFFSET 8'h00
`define WAKE_STAT_OFFSET 8'h04

`define WAKE_CTRL_EN_BIT 0
`define WAKE_CTRL_MASK_A_BIT 1
`define WAKE_CTRL_MASK_B_BIT 2
`define WAKE_CTRL_RESET 3'h0

`define WAKE_STAT_LEVEL_BIT 0
`define WAKE_STAT_FLAG_A_BIT 1
`define WAKE_STAT_FLAG_B_BIT 2

`define WAKE_CLK_MHZ 50
`define WAKE_FILTER_MIN_NS 10000
`define WAKE_FILTER_MAX_NS 25000
`define WAKE_FILTER_CYCLES ((`WAKE_FILTER_MIN_NS * `WAKE_CLK_MHZ + 999) / 1000)

`endif

/* File: hw/wake_pkg.sv */
// types shared by the wake detector modules
package wake_pkg;

   typedef enum logic [6:0] {
      MODE_INIT     = 7'h01,
      MODE_NORMAL   = 7'h02,
      MODE_STOP     = 7'h04,
      MODE_FLASH    = 7'h08,
      MODE_SLEEP    = 7'h10,
      MODE_FAILSAFE = 7'h20,
      MODE_RESTART  = 7'h40
   } mode_type;

endpackage

/* File: hw/wake_filter_if.sv */
// signals between the glitch filter and the wake control logic
`timescale 1ns/1ps
interface wake_filter_if;
   logic run;
   logic pin_now;
   logic level;
   logic rise;
   logic fall;
   modport filt (input run, output pin_now, output level, output rise, output fall);
   modport user (output run, input pin_now, input level, input rise, input fall);
endinterface

/* File: hw/wake_glitch_filter.sv */
// synchroniser and persistence filter for the wake pin
`timescale 1ns/1ps
`include "wake_pin_detector_regs.svh"
module wake_glitch_filter #(
   parameter int FILTER_CYCLES = `WAKE_FILTER_CYCLES,
   parameter int CNT_W = 11
) (
   input wire logic clk,          // 50 MHz
   input wire logic rst_b,        // async reset, active low
   input wire logic pin,          // raw wake pin
   wake_filter_if.filt fi         // filtered events
);
   localparam logic [CNT_W-1:0] LAST = CNT_W'(FILTER_CYCLES - 1);

   logic sync1_q;
   logic sync2_q;
   logic level_q;
   logic rise_q;
   logic fall_q;
   logic [CNT_W-1:0] cnt_q;
   logic prev_q;
   logic [CNT_W-1:0] hold_q;

   if (FILTER_CYCLES < 2 || FILTER_CYCLES >= (1 << CNT_W)) begin : g_chk
      $error("FILTER_CYCLES does not fit the counter");
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
      end else begin
         sync1_q <= pin;
         sync2_q <= sync1_q;
      end
   end

   // new level must differ for FILTER_CYCLES cycles in a row
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         level_q <= 1'b0;
         cnt_q <= '0;
         rise_q <= 1'b0;
         fall_q <= 1'b0;
      end else begin
         rise_q <= 1'b0;
         fall_q <= 1'b0;
         if (!fi.run) begin
            level_q <= sync2_q;
            cnt_q <= '0;
         end else if (sync2_q == level_q) begin
            cnt_q <= '0;
         end else if (cnt_q == LAST) begin
            level_q <= sync2_q;
            cnt_q <= '0;
            rise_q <= sync2_q;
            fall_q <= ~sync2_q;
         end else begin
            cnt_q <= cnt_q + 1'b1;
         end
      end
   end

   // helper for checks: length of the present stable run of the pin
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         prev_q <= 1'b0;
         hold_q <= '0;
      end else begin
         prev_q <= sync2_q;
         if (sync2_q != prev_q) begin
            hold_q <= '0;
         end else if (hold_q != {CNT_W{1'b1}}) begin
            hold_q <= hold_q + 1'b1;
         end
      end
   end

   assign fi.pin_now = sync2_q;
   assign fi.level = level_q;
   assign fi.rise = rise_q;
   assign fi.fall = fall_q;

   property p_persist;
      @(posedge clk) disable iff (!rst_b)
      (rise_q || fall_q) |-> $past(hold_q) >= LAST - 1'b1;
   endproperty
   a_persist: assert property (p_persist) else $error("edge accepted too early");

   property p_restart;
      @(posedge clk) disable iff (!rst_b)
      (fi.run && sync2_q == level_q) |=> cnt_q == '0;
   endproperty
   a_restart: assert property (p_restart) else $error("count not restarted");

   property p_both_dirs;
      @(posedge clk) disable iff (!rst_b)
      (fi.run && $past(fi.run) && $changed(level_q)) |->
         (rise_q == level_q) && (fall_q == !level_q);
   endproperty
   a_both_dirs: assert property (p_both_dirs) else $error("edge direction lost");
endmodule

/* File: verif/wake_line_model.sv */
// external switch line driving the wake pin: steady moves and short disturbances
`timescale 1ns/1ps
module wake_line_model (
   input wire logic clk,        // 50 MHz
   input wire logic go,         // one-cycle command
   input wire logic lvl,        // level to drive
   input wire logic [7:0] hold, // 0 = stay, else cycles before returning
   output logic pin             // wake line
);
   logic [7:0] left_q;
   logic home_q;
   initial begin
      pin = 1'b0;
      left_q = 8'h00;
      home_q = 1'b0;
   end
   // a disturbance returns to the previous level after hold cycles
   always @(posedge clk) begin
      if (go) begin
         home_q <= (hold == 8'h00) ? lvl : pin;
         pin <= lvl;
         left_q <= hold;
      end else if (left_q != 8'h00) begin
         left_q <= left_q - 8'h01;
         if (left_q == 8'h01) begin
            pin <= home_q;
         end
      end
   end
endmodule

/* File: verif/tb_wake_pin_detector.sv */
// self-checking bench of the wake pin detector
`timescale 1ns/1ps
`include "wake_pin_detector_regs.svh"
`define CHK(a, e, m) begin n_tests++; if ((a) !== (e)) begin failures++; \
   $display("BAD %0t %s", $time, m); end end
module tb_wake_pin_detector;
   localparam int FILT = 8;
   localparam int W = FILT + 8;
   logic clk = 1'b0, rst_b = 1'b0, supply_ok = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic go = 1'b0, lvl = 1'b0, pin;
   logic [7:0] hold = 8'h00, reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
   logic wake_from_sleep, restart_req, wake_irq;
   wake_pkg::mode_type mode = wake_pkg::MODE_NORMAL;
   int failures = 0, n_tests = 0;
   wake_pin_detector #(.FILTER_CYCLES(FILT), .CNT_W(11)) dut (.clk(clk), .rst_b(rst_b),
      .wake_input_pin(pin), .supply_ok(supply_ok), .mode(mode), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .wake_from_sleep(wake_from_sleep), .restart_req(restart_req), .wake_irq(wake_irq));
   wake_line_model line (.clk(clk), .go(go), .lvl(lvl), .hold(hold), .pin(pin));
   initial begin
      forever #10 clk = ~clk;
   end
   task give_verdict;
      $display("tests %0d failures %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk) begin reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= v; end
      @(posedge clk) reg_wr <= 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e, input string m);
      @(posedge clk) begin reg_rd <= 1'b1; reg_addr <= a; end
      @(posedge clk) reg_rd <= 1'b0;
      @(negedge clk) d = reg_rdata;
      `CHK(d, e, m)
   endtask
   task move(input logic l, input logic [7:0] h);
      @(posedge clk) begin go <= 1'b1; lvl <= l; hold <= h; end
      @(posedge clk) go <= 1'b0;
   endtask
   task wait_out(input int w, input string m);
      int i;
      for (i = 0; i < 40; i++) begin
         @(negedge clk);
         if ((w == 0 && wake_irq === 1'b1) || (w == 1 && wake_from_sleep === 1'b1) ||
            (w == 2 && restart_req === 1'b1)) break;
      end
      n_tests++;
      if (i == 40) begin
         failures++;
         $display("BAD %0t %s never rose", $time, m);
         give_verdict;
      end
   endtask
   initial begin
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      rd(`WAKE_CTRL_OFFSET, 32'h0, "ctrl reset");
      rd(`WAKE_STAT_OFFSET, 32'h0, "stat reset");
      wr(8'h08, 32'h7);
      rd(8'h08, 32'h0, "unmapped read");
      rd(`WAKE_CTRL_OFFSET, 32'h0, "unmapped write leaked");
      $display("test reset done");
      wr(`WAKE_CTRL_OFFSET, 32'h1);
      move(1'b1, 8'h04);
      repeat (W) @(posedge clk);
      rd(`WAKE_STAT_OFFSET, 32'h0, "short pulse accepted");
      move(1'b1, 8'h06);
      repeat (7) @(posedge clk);
      move(1'b1, 8'h06);
      repeat (W) @(posedge clk);
      rd(`WAKE_STAT_OFFSET, 32'h0, "count not restarted");
      $display("test filter done");
      move(1'b1, 8'h00);
      repeat (FILT - 2) @(negedge clk);
      `CHK(wake_irq, 1'b0, "irq before filter time")
      wait_out(0, "rise irq");
      rd(`WAKE_STAT_OFFSET, 32'h3, "rise flag and level");
      wr(`WAKE_CTRL_OFFSET, 32'h3);
      repeat (2) @(negedge clk);
      `CHK(wake_irq, 1'b0, "rise mask")
      wr(`WAKE_STAT_OFFSET, 32'h2);
      rd(`WAKE_STAT_OFFSET, 32'h1, "rise clear");
      move(1'b0, 8'h00);
      repeat (FILT + 1) @(posedge clk);
      wr(`WAKE_STAT_OFFSET, 32'h6);
      wait_out(0, "fall irq under rise mask");
      rd(`WAKE_STAT_OFFSET, 32'h4, "fall flag");
      wr(`WAKE_CTRL_OFFSET, 32'h5);
      repeat (2) @(negedge clk);
      `CHK(wake_irq, 1'b0, "fall mask")
      $display("test edges done");
      @(posedge clk) mode <= wake_pkg::MODE_SLEEP;
      repeat (2) @(negedge clk);
      `CHK(wake_from_sleep, 1'b1, "leftover flag wake")
      @(posedge clk) mode <= wake_pkg::MODE_NORMAL;
      wr(`WAKE_STAT_OFFSET, 32'h6);
      wr(`WAKE_CTRL_OFFSET, 32'h1);
      @(posedge clk) mode <= wake_pkg::MODE_SLEEP;
      repeat (2) @(negedge clk);
      `CHK(wake_from_sleep, 1'b0, "clean sleep woke")
      move(1'b1, 8'h00);
      wait_out(1, "sleep wake");
      rd(`WAKE_STAT_OFFSET, 32'h0, "status in sleep");
      $display("test sleep done");
      @(posedge clk) mode <= wake_pkg::MODE_NORMAL;
      wr(`WAKE_CTRL_OFFSET, 32'h0);
      move(1'b0, 8'h00);
      repeat (W) @(posedge clk);
      rd(`WAKE_STAT_OFFSET, 32'h0, "disabled edge flagged");
      @(posedge clk) mode <= wake_pkg::MODE_FAILSAFE;
      move(1'b1, 8'h00);
      wait_out(2, "fail-safe restart");
      $display("test fail-safe done");
      @(posedge clk) mode <= wake_pkg::MODE_FLASH;
      rd(`WAKE_STAT_OFFSET, 32'h1, "level in flash");
      wr(`WAKE_CTRL_OFFSET, 32'h1);
      @(posedge clk) supply_ok <= 1'b0;
      move(1'b0, 8'h00);
      repeat (W) @(posedge clk);
      supply_ok <= 1'b1;
      repeat (W) @(posedge clk);
      rd(`WAKE_STAT_OFFSET, 32'h0, "edge while supply off");
      @(posedge clk) mode <= wake_pkg::MODE_STOP;
      move(1'b1, 8'h00);
      repeat (FILT + 1) @(posedge clk);
      wr(`WAKE_STAT_OFFSET, 32'h6);
      wait_out(0, "stop irq");
      rd(`WAKE_STAT_OFFSET, 32'h3, "stop flag and level");
      $display("test supply and stop done");
      give_verdict;
   end
endmodule
